// file: drive_pkg.sv
// Purpose: Shared constants for the drive setpoint link and its controller.
// Assumes: pclk at 40 MHz; object bus and pulse pins on the drive link.
// Notes:
// Contract
// - Host writes mode 9 for cyclic velocity
// - Host writes mode 10 for cyclic torque
// - Torque mode works only under closed loop
// - Control word bits carry no cyclic meaning
// - Status bit 8 shows fieldbus sync
// - Velocity mode: bit 12 shows setpoint used
// - Torque mode: bit 12 shows setpoint used
// - Cyclic modes keep bits 10, 13 reserved
// - Host writes a new setpoint every cycle
// - Cycle period is value times one millisecond
// - Torque command is bounded by torque ceiling
// - Velocity quick-stop brakes with set deceleration
// - Limit switches stay active in these modes
// - Host writes mode -1 for step/direction
// - One scaled step per accepted pulse
// - Pulses at most 1 MHz, 200 ns high
// - Step width equals numerator over denominator
// - Four full steps per pole pair
// - Wait 35 us after direction change
// - Step mode closed loop sets bit 13
// - Subtype 0: pulse input plus direction level
// - Subtype 1: input used chooses direction
// - Following error after window exceeds timeout
package drive_pkg;
	localparam logic [15:0] OBJ_STEP_NUM   = 16'h2057;
	localparam logic [15:0] OBJ_STEP_DEN   = 16'h2058;
	localparam logic [15:0] OBJ_SUBTYPE    = 16'h205B;
	localparam logic [15:0] OBJ_POLE_PAIRS = 16'h2030;
	localparam logic [15:0] OBJ_CONTROL    = 16'h6040;
	localparam logic [15:0] OBJ_STATUS     = 16'h6041;
	localparam logic [15:0] OBJ_QS_OPTION  = 16'h605A;
	localparam logic [15:0] OBJ_MODE       = 16'h6060;
	localparam logic [15:0] OBJ_FE_WINDOW  = 16'h6065;
	localparam logic [15:0] OBJ_FE_TIMEOUT = 16'h6066;
	localparam logic [15:0] OBJ_TORQUE_SP  = 16'h6071;
	localparam logic [15:0] OBJ_TORQUE_MAX = 16'h6072;
	localparam logic [15:0] OBJ_QS_DECEL   = 16'h6085;
	localparam logic [15:0] OBJ_CYCLE_PER  = 16'h60C2;
	localparam logic [15:0] OBJ_VEL_SP     = 16'h60FF;

	localparam logic [31:0] STEP_NUM_RST   = 32'h0000_0080;
	localparam logic [31:0] STEP_DEN_RST   = 32'h0000_0001;
	localparam logic [31:0] SUBTYPE_RST    = 32'h0000_0000;
	localparam logic [7:0]  POLE_PAIRS_RST = 8'h32;
	localparam logic [15:0] TORQUE_MAX_RST = 16'h03E8;
	localparam logic [31:0] FE_WINDOW_RST  = 32'h0000_0100;
	localparam logic [15:0] FE_TIMEOUT_RST = 16'h000A;
	localparam logic [7:0]  CYCLE_PER_RST  = 8'h01;

	localparam logic [7:0] MODE_CYC_VEL  = 8'h09;
	localparam logic [7:0] MODE_CYC_TORQ = 8'h0A;
	localparam logic [7:0] MODE_STEP_DIR = 8'hFF;
	localparam logic [31:0] SUB_PULSE_DIR = 32'h0000_0000;
	localparam logic [31:0] SUB_DUAL_PULSE = 32'h0000_0001;

	localparam int SW_SYNC_BIT   = 8;
	localparam int SW_RSV10_BIT  = 10;
	localparam int SW_TARGET_BIT = 12;
	localparam int SW_FERR_BIT   = 13;
	localparam int FULL_STEPS_PER_PP = 4;

	localparam int CLK_PERIOD_NS  = 25;
	localparam int MS_NS          = 1000000;
	localparam int PULSE_HI_NS    = 200;
	localparam int PULSE_PER_NS   = 1000;
	localparam int DIR_SETTLE_NS  = 35000;
	localparam int MS_CYCLES      = MS_NS / CLK_PERIOD_NS;
	localparam int PULSE_HI_CYC   = (PULSE_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_PER_CYC  = (PULSE_PER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DIR_SETTLE_CYC = (DIR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [7:0] APB_OBJ_IDX  = 8'h00;
	localparam logic [7:0] APB_OBJ_DATA = 8'h04;
	localparam logic [7:0] APB_OBJ_CMD  = 8'h08;
	localparam logic [7:0] APB_STATUS   = 8'h0C;
	localparam logic [7:0] APB_RDATA    = 8'h10;
	localparam logic [7:0] APB_SETPOINT = 8'h14;
	localparam logic [7:0] APB_CYC_CFG  = 8'h18;
	localparam logic [7:0] APB_STEP     = 8'h1C;
endpackage : drive_pkg

// file: drive_link_if.sv
`timescale 1ns/100ps
// Purpose: Link between motion controller and drive: object bus, sync, pulse pins.
// Assumes: Both ends on pclk; pulse pins treated as asynchronous by the drive.
// Notes: Object request held until a one-cycle ack.
interface drive_link_if;
	logic        obj_wr;    // Object write request
	logic        obj_rd;    // Object read request
	logic [15:0] obj_idx;   // Object index
	logic [31:0] obj_wdata; // Write data
	logic        obj_ack;   // One-cycle answer
	logic        obj_err;   // Unknown or read-only object, with ack
	logic [31:0] obj_rdata; // Read data, with ack
	logic        sync;      // One-cycle fieldbus sync strobe
	logic        pulse_a;   // Step pulse, or forward pulse
	logic        pulse_b;   // Reverse pulse
	logic        dir;       // Direction level, high forward

	modport dev (input obj_wr, obj_rd, obj_idx, obj_wdata, sync, pulse_a, pulse_b, dir,
		output obj_ack, obj_err, obj_rdata);
	modport ctl (output obj_wr, obj_rd, obj_idx, obj_wdata, sync, pulse_a, pulse_b, dir,
		input obj_ack, obj_err, obj_rdata);
endinterface : drive_link_if

// file: drive_end.sv
`timescale 1ns/100ps
// Purpose: Drive end: object store, mode handling, status word, step scaling.
// Assumes: actual_pos, closed_loop, quick_stop on pclk; limits and pulses async.
// Notes: Step width fixed by a serial divide after numerator/denominator writes.
module drive_end #(
	parameter int MS_CYC = drive_pkg::MS_CYCLES
) (
	input  wire logic        pclk,        // 40 MHz clock
	input  wire logic        presetn,     // Async reset, active low
	drive_link_if.dev        link,        // Link to controller
	input  wire logic        closed_loop, // Closed loop control active
	input  wire logic        quick_stop,  // Quick-stop requested
	input  wire logic        limit_pos,   // Positive limit switch pin
	input  wire logic        limit_neg,   // Negative limit switch pin
	input  wire logic [31:0] actual_pos,  // Measured position
	output logic      [31:0] vel_cmd,     // Velocity command
	output logic      [15:0] torque_cmd,  // Torque command, per ceiling
	output logic      [15:0] qs_option,   // Quick-stop option in force
	output logic             qs_active,   // Quick-stop braking
	output logic      [31:0] step_pos,    // Commanded position
	output logic      [15:0] full_steps_rev, // Full steps per revolution
	output logic      [15:0] status_word  // Status word
);
	import drive_pkg::*;

	typedef struct packed {
		logic [7:0]  mode;
		logic [15:0] ctrl;
		logic [15:0] qs_opt;
		logic [15:0] tq_sp;
		logic [15:0] tq_max;
		logic [31:0] qs_dec;
		logic [7:0]  cyc_per;
		logic [31:0] vel_sp;
		logic [31:0] num;
		logic [31:0] den;
		logic [31:0] subtype;
		logic [31:0] fe_win;
		logic [15:0] fe_to;
		logic [7:0]  pole_pairs;
		logic        ack;
		logic        err;
		logic [31:0] rdata;
		logic [4:0]  sync1;
		logic [4:0]  sync2;
		logic        pa_d;
		logic        pb_d;
		logic        div_busy;
		logic [5:0]  div_cnt;
		logic [31:0] div_n;
		logic [32:0] div_r;
		logic [31:0] div_q;
		logic [31:0] quo;
		logic [31:0] rem;
		logic [31:0] frac;
		logic [31:0] pos;
		logic [15:0] ms_cnt;
		logic        ms_tick;
		logic [8:0]  cyc_ms;
		logic        in_sync;
		logic [15:0] fe_ms;
		logic        fe_flag;
		logic [31:0] vel;
		logic [15:0] tq;
		logic        qs_on;
		logic [15:0] qs_out;
		logic [15:0] spr;
		logic [15:0] sw;
	} dstate_t;

	dstate_t q, d;

	logic pa_s, pb_s, dir_s, lp_s, ln_s;
	assign {pa_s, pb_s, dir_s, lp_s, ln_s} = q.sync2;

	always_comb begin
		logic        wr_go;
		logic        rd_go;
		logic        step_ev;
		logic        step_fwd;
		logic [32:0] r2;
		logic [31:0] fsum;
		logic [31:0] inc;
		logic [31:0] ferr;
		logic [31:0] vabs;
		logic        is_vel, is_tq, is_step;
		d = q;
		wr_go = link.obj_wr & ~q.ack;
		rd_go = link.obj_rd & ~q.ack;
		step_ev = 1'b0;
		step_fwd = 1'b0;
		r2 = 33'h0_0000_0000;
		fsum = 32'h0000_0000;
		inc = 32'h0000_0000;
		ferr = q.pos - actual_pos;
		vabs = q.vel[31] ? -q.vel : q.vel;
		is_vel = q.mode == MODE_CYC_VEL;
		is_tq = q.mode == MODE_CYC_TORQ;
		is_step = q.mode == MODE_STEP_DIR;

		// Pin synchronisers: first stage feeds only the second
		d.sync1 = {link.pulse_a, link.pulse_b, link.dir, limit_pos, limit_neg};
		d.sync2 = q.sync1;
		d.pa_d = pa_s;
		d.pb_d = pb_s;

		// Object bus
		d.ack = wr_go | rd_go;
		d.err = 1'b0;
		d.rdata = 32'h0000_0000;
		if (wr_go) begin
			case (link.obj_idx)
				OBJ_CONTROL:    d.ctrl = link.obj_wdata[15:0];
				OBJ_MODE:       d.mode = link.obj_wdata[7:0];
				OBJ_QS_OPTION:  d.qs_opt = link.obj_wdata[15:0];
				OBJ_TORQUE_SP:  d.tq_sp = link.obj_wdata[15:0];
				OBJ_TORQUE_MAX: d.tq_max = link.obj_wdata[15:0];
				OBJ_QS_DECEL:   d.qs_dec = link.obj_wdata;
				OBJ_CYCLE_PER:  d.cyc_per = link.obj_wdata[7:0];
				OBJ_VEL_SP:     d.vel_sp = link.obj_wdata;
				OBJ_STEP_NUM:   d.num = link.obj_wdata;
				OBJ_STEP_DEN:   d.den = link.obj_wdata;
				OBJ_SUBTYPE:    d.subtype = link.obj_wdata;
				OBJ_FE_WINDOW:  d.fe_win = link.obj_wdata;
				OBJ_FE_TIMEOUT: d.fe_to = link.obj_wdata[15:0];
				OBJ_POLE_PAIRS: d.pole_pairs = link.obj_wdata[7:0];
				default:        d.err = 1'b1;
			endcase
			if (link.obj_idx == OBJ_STEP_NUM || link.obj_idx == OBJ_STEP_DEN) begin
				d.div_busy = 1'b1;
				d.div_cnt = 6'd0;
				d.div_n = d.num;
				d.div_r = 33'h0_0000_0000;
				d.div_q = 32'h0000_0000;
				d.frac = 32'h0000_0000;
			end
		end else if (rd_go) begin
			case (link.obj_idx)
				OBJ_CONTROL:    d.rdata = {16'h0000, q.ctrl};
				OBJ_STATUS:     d.rdata = {16'h0000, q.sw};
				OBJ_MODE:       d.rdata = {24'h00_0000, q.mode};
				OBJ_QS_OPTION:  d.rdata = {16'h0000, q.qs_opt};
				OBJ_TORQUE_SP:  d.rdata = {16'h0000, q.tq_sp};
				OBJ_TORQUE_MAX: d.rdata = {16'h0000, q.tq_max};
				OBJ_QS_DECEL:   d.rdata = q.qs_dec;
				OBJ_CYCLE_PER:  d.rdata = {24'h00_0000, q.cyc_per};
				OBJ_VEL_SP:     d.rdata = q.vel_sp;
				OBJ_STEP_NUM:   d.rdata = q.num;
				OBJ_STEP_DEN:   d.rdata = q.den;
				OBJ_SUBTYPE:    d.rdata = q.subtype;
				OBJ_FE_WINDOW:  d.rdata = q.fe_win;
				OBJ_FE_TIMEOUT: d.rdata = {16'h0000, q.fe_to};
				OBJ_POLE_PAIRS: d.rdata = {24'h00_0000, q.pole_pairs};
				default:        d.err = 1'b1;
			endcase
		end

		// Serial divide: step width = numerator / denominator
		if (q.div_busy) begin
			r2 = {q.div_r[31:0], q.div_n[31]};
			d.div_n = {q.div_n[30:0], 1'b0};
			if (r2 >= {1'b0, q.den} && q.den != 32'h0000_0000) begin
				d.div_r = r2 - {1'b0, q.den};
				d.div_q = {q.div_q[30:0], 1'b1};
			end else begin
				d.div_r = r2;
				d.div_q = {q.div_q[30:0], 1'b0};
			end
			d.div_cnt = q.div_cnt + 6'd1;
			if (q.div_cnt == 6'd31) begin
				d.div_busy = 1'b0;
				d.quo = d.div_q;
				d.rem = d.div_r[31:0];
			end
		end

		// Millisecond base and fieldbus sync watch
		d.ms_tick = 1'b0;
		d.ms_cnt = q.ms_cnt + 16'd1;
		if (q.ms_cnt == 16'(MS_CYC - 1)) begin
			d.ms_cnt = 16'h0000;
			d.ms_tick = 1'b1;
		end
		if (link.sync) begin
			d.cyc_ms = 9'h000;
			d.in_sync = q.cyc_per != 8'h00;
		end else if (q.ms_tick) begin
			d.cyc_ms = (q.cyc_ms == 9'h1FF) ? q.cyc_ms : q.cyc_ms + 9'd1;
			if (q.cyc_ms >= {1'b0, q.cyc_per})
				d.in_sync = 1'b0;
		end

		// Step/direction input decode
		if (is_step && !q.div_busy) begin
			if (q.subtype == SUB_DUAL_PULSE) begin
				step_ev = (pa_s & ~q.pa_d) ^ (pb_s & ~q.pb_d);
				step_fwd = pa_s & ~q.pa_d;
			end else begin
				step_ev = pa_s & ~q.pa_d;
				step_fwd = dir_s;
			end
			if ((step_fwd && lp_s) || (!step_fwd && ln_s))
				step_ev = 1'b0;
		end
		if (step_ev) begin
			fsum = q.frac + q.rem;
			inc = q.quo;
			if (fsum >= q.den && q.den != 32'h0000_0000) begin
				fsum = fsum - q.den;
				inc = q.quo + 32'd1;
			end
			d.frac = fsum;
			d.pos = step_fwd ? q.pos + inc : q.pos - inc;
		end
		d.spr = 16'(FULL_STEPS_PER_PP) * {8'h00, q.pole_pairs};

		// Following error in step mode under closed loop
		if (is_step && closed_loop) begin
			if (ferr[31] ? (-ferr > q.fe_win) : (ferr > q.fe_win)) begin
				if (q.ms_tick) begin
					d.fe_ms = (q.fe_ms == 16'hFFFF) ? q.fe_ms : q.fe_ms + 16'd1;
					if (q.fe_ms >= q.fe_to)
						d.fe_flag = 1'b1;
				end
			end else begin
				d.fe_ms = 16'h0000;
				d.fe_flag = 1'b0;
			end
		end else begin
			d.fe_ms = 16'h0000;
			d.fe_flag = 1'b0;
		end

		// Cyclic velocity with quick-stop braking
		d.qs_on = is_vel & quick_stop;
		d.qs_out = (is_vel & quick_stop) ? q.qs_opt : 16'h0000;
		if (is_vel) begin
			if (quick_stop) begin
				if (q.ms_tick) begin
					if (vabs <= q.qs_dec)
						d.vel = 32'h0000_0000;
					else
						d.vel = q.vel[31] ? q.vel + q.qs_dec : q.vel - q.qs_dec;
				end
			end else if (link.sync) begin
				d.vel = q.vel_sp;
			end
			if ((!d.vel[31] && d.vel != 32'h0000_0000 && lp_s) || (d.vel[31] && ln_s))
				d.vel = 32'h0000_0000;
		end else begin
			d.vel = 32'h0000_0000;
		end

		// Cyclic torque, bounded by the ceiling
		if (is_tq && closed_loop) begin
			if (link.sync) begin
				d.tq = q.tq_sp;
				if (!q.tq_sp[15] && q.tq_sp > q.tq_max)
					d.tq = q.tq_max;
				else if (q.tq_sp[15] && -q.tq_sp > q.tq_max)
					d.tq = -q.tq_max;
			end
			if ((!d.tq[15] && d.tq != 16'h0000 && lp_s) || (d.tq[15] && ln_s))
				d.tq = 16'h0000;
		end else begin
			d.tq = 16'h0000;
		end

		// Status word
		d.sw = 16'h0000;
		if (is_vel || is_tq) begin
			d.sw[SW_SYNC_BIT] = q.in_sync;
			d.sw[SW_TARGET_BIT] = q.in_sync & ~quick_stop & (is_vel | closed_loop);
			d.sw[SW_RSV10_BIT] = 1'b0;
		end else if (is_step) begin
			d.sw[SW_FERR_BIT] = q.fe_flag;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.num <= STEP_NUM_RST;
			q.den <= STEP_DEN_RST;
			q.quo <= STEP_NUM_RST;
			q.subtype <= SUBTYPE_RST;
			q.tq_max <= TORQUE_MAX_RST;
			q.fe_win <= FE_WINDOW_RST;
			q.fe_to <= FE_TIMEOUT_RST;
			q.cyc_per <= CYCLE_PER_RST;
			q.pole_pairs <= POLE_PAIRS_RST;
		end else begin
			q <= d;
		end
	end

	assign link.obj_ack   = q.ack;
	assign link.obj_err   = q.err;
	assign link.obj_rdata = q.rdata;
	assign vel_cmd        = q.vel;
	assign torque_cmd     = q.tq;
	assign qs_option      = q.qs_out;
	assign qs_active      = q.qs_on;
	assign step_pos       = q.pos;
	assign full_steps_rev = q.spr;
	assign status_word    = q.sw;
endmodule : drive_end

// file: motion_ctl_end.sv
`timescale 1ns/100ps
// Purpose: Controller end: APB registers, object access, cyclic setpoint, pulses.
// Assumes: APB master on pclk; drive end on the same link.
// Notes: Cyclic setpoint write waits for an idle object bus.
module motion_ctl_end #(
	parameter int MS_CYC = drive_pkg::MS_CYCLES
) (
	input  wire logic        pclk,    // 40 MHz clock
	input  wire logic        presetn, // Async reset, active low
	input  wire logic        psel,    // APB select
	input  wire logic        penable, // APB enable
	input  wire logic        pwrite,  // APB write
	input  wire logic [7:0]  paddr,   // APB byte address
	input  wire logic [31:0] pwdata,  // APB write data
	output logic      [31:0] prdata,  // APB read data
	output logic             pready,  // APB ready
	output logic             pslverr, // APB error
	drive_link_if.ctl        link     // Link to drive
);
	import drive_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE   = 3'b000,
		S_OBJ    = 3'b001,
		S_SETTLE = 3'b010,
		S_HIGH   = 3'b011,
		S_LOW    = 3'b100
	} cstate_t;

	typedef struct packed {
		cstate_t     st;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic [15:0] idx;
		logic [31:0] data;
		logic [31:0] rdata;
		logic        err;
		logic        req_wr;
		logic        req_rd;
		logic [15:0] lidx;
		logic [31:0] lwdata;
		logic [31:0] setp;
		logic [15:0] cfg;
		logic [15:0] steps;
		logic        sdir;
		logic        cur_dir;
		logic        pa;
		logic        pb;
		logic        sync;
		logic [10:0] tmr;
		logic [15:0] ms_cnt;
		logic [7:0]  cyc_ms;
		logic        auto_due;
	} cst_t;

	cst_t q, d;

	always_comb begin
		logic acc;
		logic busy;
		d = q;
		acc = psel & penable & ~q.pready;
		busy = q.st != S_IDLE;
		d.pready = acc;
		d.pslverr = 1'b0;
		d.sync = 1'b0;

		// Cycle timer: sync strobe and setpoint due each period
		d.ms_cnt = q.ms_cnt + 16'd1;
		if (q.ms_cnt == 16'(MS_CYC - 1)) begin
			d.ms_cnt = 16'h0000;
			d.cyc_ms = q.cyc_ms + 8'd1;
			if (q.cfg[0] && q.cyc_ms + 8'd1 >= q.cfg[15:8]) begin
				d.cyc_ms = 8'h00;
				d.sync = 1'b1;
				d.auto_due = 1'b1;
			end
		end

		// Link sequencer
		case (q.st)
			S_IDLE: begin
				if (q.auto_due) begin
					d.auto_due = 1'b0;
					d.req_wr = 1'b1;
					d.lidx = q.cfg[1] ? OBJ_TORQUE_SP : OBJ_VEL_SP;
					d.lwdata = q.setp;
					d.st = S_OBJ;
				end else if (q.steps != 16'h0000) begin
					if (q.sdir != q.cur_dir) begin
						d.cur_dir = q.sdir;
						d.tmr = 11'(DIR_SETTLE_CYC - 1);
						d.st = S_SETTLE;
					end else begin
						d.tmr = 11'(PULSE_HI_CYC - 1);
						d.st = S_HIGH;
					end
				end
			end
			S_OBJ: begin
				if (link.obj_ack) begin
					d.req_wr = 1'b0;
					d.req_rd = 1'b0;
					d.err = link.obj_err;
					if (q.req_rd)
						d.rdata = link.obj_rdata;
					d.st = S_IDLE;
				end
			end
			S_SETTLE: begin
				d.tmr = q.tmr - 11'd1;
				if (q.tmr == 11'd0) begin
					d.tmr = 11'(PULSE_HI_CYC - 1);
					d.st = S_HIGH;
				end
			end
			S_HIGH: begin
				d.pa = ~(q.cfg[2] & ~q.cur_dir);
				d.pb = q.cfg[2] & ~q.cur_dir;
				d.tmr = q.tmr - 11'd1;
				if (q.tmr == 11'd0) begin
					d.tmr = 11'(PULSE_PER_CYC - PULSE_HI_CYC - 2);
					d.st = S_LOW;
				end
			end
			S_LOW: begin
				d.pa = 1'b0;
				d.pb = 1'b0;
				d.tmr = q.tmr - 11'd1;
				if (q.tmr == 11'd0) begin
					d.steps = q.steps - 16'd1;
					d.st = S_IDLE;
				end
			end
			default: d.st = S_IDLE;
		endcase

		// APB register access
		if (acc) begin
			d.prdata = 32'h0000_0000;
			case (paddr)
				APB_OBJ_IDX: begin
					if (pwrite) d.idx = pwdata[15:0];
					d.prdata = {16'h0000, q.idx};
				end
				APB_OBJ_DATA: begin
					if (pwrite) d.data = pwdata;
					d.prdata = q.data;
				end
				APB_OBJ_CMD: begin
					if (pwrite && !busy && !q.auto_due && q.steps == 16'h0000 && pwdata[1:0] != 2'b00) begin
						d.req_wr = pwdata[0];
						d.req_rd = ~pwdata[0];
						d.lidx = q.idx;
						d.lwdata = q.data;
						d.st = S_OBJ;
					end
				end
				APB_STATUS: d.prdata = {q.steps, 14'h0000, q.err, busy};
				APB_RDATA: d.prdata = q.rdata;
				APB_SETPOINT: begin
					if (pwrite) d.setp = pwdata;
					d.prdata = q.setp;
				end
				APB_CYC_CFG: begin
					if (pwrite) d.cfg = pwdata[15:0];
					d.prdata = {16'h0000, q.cfg};
				end
				APB_STEP: begin
					if (pwrite && q.steps == 16'h0000) begin
						d.steps = pwdata[15:0];
						d.sdir = pwdata[16];
					end
					d.prdata = {15'h0000, q.sdir, q.steps};
				end
				default: d.pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.cur_dir <= 1'b1;
			q.sdir <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign prdata         = q.prdata;
	assign pready         = q.pready;
	assign pslverr        = q.pslverr;
	assign link.obj_wr    = q.req_wr;
	assign link.obj_rd    = q.req_rd;
	assign link.obj_idx   = q.lidx;
	assign link.obj_wdata = q.lwdata;
	assign link.sync      = q.sync;
	assign link.pulse_a   = q.pa;
	assign link.pulse_b   = q.pb;
	assign link.dir       = q.cur_dir;
endmodule : motion_ctl_end

// file: drive_link_chk.sv
`timescale 1ns/100ps
// Purpose: Timing checks on the link between the controller end and the drive end.
// Assumes: One clock domain; gap counters saturate, so first events after reset pass.
// Notes: MS_CYC must match the value given to both ends.
module drive_link_chk #(
	parameter int MS_CYC = drive_pkg::MS_CYCLES
) (
	input wire logic        pclk,      // Clock
	input wire logic        presetn,   // Async reset, active low
	input wire logic        obj_wr,    // Write request
	input wire logic        obj_rd,    // Read request
	input wire logic [15:0] obj_idx,   // Object index
	input wire logic [31:0] obj_wdata, // Write data
	input wire logic        obj_ack,   // Answer
	input wire logic        sync,      // Sync strobe
	input wire logic        pulse_a,   // Step or forward pulse
	input wire logic        pulse_b,   // Reverse pulse
	input wire logic        dir        // Direction level
);
	typedef struct packed {logic [15:0] stp, drc, syn; logic stp_l, dir_l;} gap_t;
	gap_t       g_q;
	gap_t       g_d;
	wire logic  step = pulse_a | pulse_b;
	function automatic logic [15:0] inc(input logic [15:0] v);
		return (v == 16'hFFFF) ? v : v + 16'h0001;
	endfunction : inc
	// Cycles since the last pulse rise, direction change and sync strobe
	always_comb begin
		g_d       = g_q;
		g_d.stp_l = step;
		g_d.dir_l = dir;
		g_d.stp   = (step && !g_q.stp_l) ? 16'h0001 : inc(g_q.stp);
		g_d.drc   = (dir != g_q.dir_l) ? 16'h0001 : inc(g_q.drc);
		g_d.syn   = sync ? 16'h0001 : inc(g_q.syn);
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			g_q <= '{16'hFFFF, 16'hFFFF, 16'hFFFF, 1'h0, 1'h1};
		end else begin
			g_q <= g_d;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_pulse_on; step [*8] ##1 !step; endsequence
	sequence s_answer; ##1 obj_ack; endsequence
	property p_pulse_on; $rose(step) |-> s_pulse_on; endproperty
	property p_pulse_gap; $rose(step) |-> g_q.stp >= 16'h0028; endproperty
	property p_dir_settle; $rose(step) |-> g_q.drc >= 16'h0578; endproperty
	property p_sync_gap; sync |-> (g_q.syn >= MS_CYC) ##1 !sync; endproperty
	property p_req_answer; $rose(obj_wr || obj_rd) |-> s_answer; endproperty
	property p_req_hold;
		(obj_wr || obj_rd) && !obj_ack |=> (obj_wr || obj_rd) && $stable(obj_idx)
			&& $stable(obj_wdata);
	endproperty
	property p_ack_release; obj_ack |=> !obj_ack && !obj_wr && !obj_rd; endproperty
	property p_one_req; !(obj_wr && obj_rd); endproperty
	a_pulse_on: assert property (p_pulse_on) else $error("Pulse high time wrong");
	a_pulse_gap: assert property (p_pulse_gap) else $error("Pulse rate too high");
	a_dir_settle: assert property (p_dir_settle) else $error("Pulse too soon");
	a_sync_gap: assert property (p_sync_gap) else $error("Sync spacing wrong");
	a_req_answer: assert property (p_req_answer) else $error("Answer late");
	a_req_hold: assert property (p_req_hold) else $error("Request not held");
	a_ack_release: assert property (p_ack_release) else $error("Request kept");
	a_one_req: assert property (p_one_req) else $error("Read and write together");
endmodule : drive_link_chk

// file: testbench.sv
`timescale 1ns/100ps
// Purpose: Drives the controller end over APB and the drive end pins directly; checks drive outputs against a small model.
// Assumes: One millisecond shortened to 40 cycles through MS_CYC.
// Notes: Object traffic is only issued while cyclic writes are off.
module testbench;
	import drive_pkg::*;
	localparam int MSC = 40;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr, oerr;
	logic        closed_loop, quick_stop, limit_pos, limit_neg, qs_active;
	logic [7:0]  paddr;
	logic [15:0] torque_cmd, qs_option, full_steps_rev, status_word, qo;
	logic [31:0] pwdata, prdata, rd, sp, actual_pos, vel_cmd, step_pos;
	int          fail_count, comparisons, exp_pos, width, n;
	drive_link_if link ();
	motion_ctl_end #(.MS_CYC(MSC)) i_motion_ctl_end (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link(link));
	drive_end #(.MS_CYC(MSC)) i_drive_end (.pclk, .presetn, .link(link), .closed_loop,
		.quick_stop, .limit_pos, .limit_neg, .actual_pos, .vel_cmd, .torque_cmd, .qs_option,
		.qs_active, .step_pos, .full_steps_rev, .status_word);
	drive_link_chk #(.MS_CYC(MSC)) i_drive_link_chk (.pclk, .presetn,
		.obj_wr(link.obj_wr), .obj_rd(link.obj_rd), .obj_idx(link.obj_idx),
		.obj_wdata(link.obj_wdata), .obj_ack(link.obj_ack), .sync(link.sync),
		.pulse_a(link.pulse_a), .pulse_b(link.pulse_b), .dir(link.dir));
	always #12.5 pclk = ~pclk;
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic test_done;
		if (fail_count == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : test_done
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd      = prdata;
		serr    = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic obj(input logic [15:0] idx, input logic [31:0] d, input logic rdq);
		apb(1'h1, APB_OBJ_IDX, {16'h0000, idx});
		apb(1'h1, APB_OBJ_DATA, d);
		apb(1'h1, APB_OBJ_CMD, rdq ? 32'h0000_0002 : 32'h0000_0001);
		do apb(1'h0, APB_STATUS, 32'h0000_0000); while (rd[0] !== 1'h0);
		oerr = rd[1];
		apb(1'h0, APB_RDATA, 32'h0000_0000);
	endtask : obj
	task automatic ms(input int k);
		repeat (k * MSC) @(posedge pclk);
	endtask : ms
	// Steps are finished once the count reads zero and 50 more cycles have passed
	task automatic steps(input int c, input logic fwd);
		apb(1'h1, APB_STEP, {15'h0000, fwd, 16'(c)});
		do apb(1'h0, APB_STATUS, 32'h0000_0000); while (rd[31:16] !== 16'h0000);
		repeat (50) @(posedge pclk);
	endtask : steps
	function automatic logic [31:0] sb(input int b);
		return 32'(status_word[b]);
	endfunction : sb
	initial begin
		repeat (40000) @(posedge pclk);
		fail_count++;
		test_done;
	end
	initial begin
		{pclk, presetn, psel, penable, pwrite, closed_loop, quick_stop} = 7'h00;
		{limit_pos, limit_neg, paddr, pwdata, actual_pos} = 74'h0;
		void'($urandom(5));
		exp_pos = 0;
		width = STEP_NUM_RST / STEP_DEN_RST;
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		obj(OBJ_STEP_NUM, 32'h0000_0000, 1'h1);
		chk("step numerator", rd, STEP_NUM_RST);
		chk("full steps", {16'h0000, full_steps_rev}, 32'(FULL_STEPS_PER_PP * POLE_PAIRS_RST));
		obj(OBJ_STEP_DEN, 32'h0000_0000, 1'h1);
		chk("step denominator", rd, STEP_DEN_RST);
		obj(OBJ_SUBTYPE, 32'h0000_0000, 1'h1);
		chk("subtype", rd, SUBTYPE_RST);
		apb(1'h0, 8'h20, 32'h0000_0000);
		chk("unmapped pslverr", 32'(serr), 32'h0000_0001);
		obj(OBJ_STATUS, 32'h0000_0001, 1'h0);
		chk("status write error", 32'(oerr), 32'h0000_0001);
		qo = 16'($urandom);
		obj(OBJ_QS_OPTION, {16'h0000, qo}, 1'h0);
		obj(OBJ_QS_DECEL, 32'h0000_0010, 1'h0);
		obj(OBJ_MODE, {24'h00_0000, MODE_CYC_VEL}, 1'h0);
		obj(OBJ_CONTROL, $urandom, 1'h0);
		sp = $urandom;
		apb(1'h1, APB_SETPOINT, sp);
		apb(1'h1, APB_CYC_CFG, 32'h0000_0101);
		ms(3);
		chk("velocity", vel_cmd, sp);
		chk("sync bit", sb(SW_SYNC_BIT), 32'h0000_0001);
		chk("target bit", sb(SW_TARGET_BIT), 32'h0000_0001);
		chk("bit 10", sb(SW_RSV10_BIT), 32'h0000_0000);
		chk("bit 13", sb(SW_FERR_BIT), 32'h0000_0000);
		sp = $urandom;
		apb(1'h1, APB_SETPOINT, sp);
		ms(3);
		chk("velocity", vel_cmd, sp);
		quick_stop <= 1'h1;
		ms(2);
		chk("quick stop", 32'(qs_active), 32'h0000_0001);
		chk("quick stop option", {16'h0000, qs_option}, {16'h0000, qo});
		chk("target bit", sb(SW_TARGET_BIT), 32'h0000_0000);
		quick_stop <= 1'h0;
		apb(1'h1, APB_CYC_CFG, 32'h0000_0000);
		ms(3);
		chk("sync bit", sb(SW_SYNC_BIT), 32'h0000_0000);
		obj(OBJ_MODE, {24'h00_0000, MODE_CYC_TORQ}, 1'h0);
		obj(OBJ_CYCLE_PER, 32'h0000_0003, 1'h0);
		sp = $urandom % 1000;
		apb(1'h1, APB_SETPOINT, sp);
		apb(1'h1, APB_CYC_CFG, 32'h0000_0103);
		ms(3);
		chk("target bit", sb(SW_TARGET_BIT), 32'h0000_0000);
		closed_loop <= 1'h1;
		ms(4);
		chk("target bit", sb(SW_TARGET_BIT), 32'h0000_0001);
		chk("torque", {16'h0000, torque_cmd}, sp);
		apb(1'h1, APB_SETPOINT, 32'h0000_07D0);
		ms(7);
		chk("torque", {16'h0000, torque_cmd}, {16'h0000, TORQUE_MAX_RST});
		apb(1'h1, APB_CYC_CFG, 32'h0000_0000);
		obj(OBJ_MODE, 32'h0000_0000, 1'h0);
		ms(1);
		chk("velocity", vel_cmd, 32'h0000_0000);
		chk("torque", {16'h0000, torque_cmd}, 32'h0000_0000);
		obj(OBJ_MODE, {24'h00_0000, MODE_STEP_DIR}, 1'h0);
		n = 1 + $urandom % 4;
		steps(n, 1'h1);
		exp_pos += n * width;
		chk("position", step_pos, 32'(exp_pos));
		obj(OBJ_STEP_NUM, 32'h0000_0200, 1'h0);
		width = 512 / STEP_DEN_RST;
		repeat (40) @(posedge pclk);
		steps(n, 1'h0);
		exp_pos -= n * width;
		chk("position", step_pos, 32'(exp_pos));
		limit_pos <= 1'h1;
		repeat (4) @(posedge pclk);
		steps(2, 1'h1);
		chk("position", step_pos, 32'(exp_pos));
		limit_pos <= 1'h0;
		obj(OBJ_SUBTYPE, 32'h0000_0001, 1'h0);
		apb(1'h1, APB_CYC_CFG, 32'h0000_0004);
		steps(n, 1'h0);
		exp_pos -= n * width;
		chk("position", step_pos, 32'(exp_pos));
		steps(1, 1'h1);
		exp_pos += width;
		chk("position", step_pos, 32'(exp_pos));
		actual_pos <= 32'(exp_pos + 1000);
		ms(12);
		chk("following error", sb(SW_FERR_BIT), 32'h0000_0001);
		actual_pos <= 32'(exp_pos);
		ms(1);
		chk("following error", sb(SW_FERR_BIT), 32'h0000_0000);
		test_done;
	end
endmodule : testbench
